// file: hdl/mfo_pkg.sv
// Package: constants, register map and function codes for the output terminal selector
// Functional notes
// - Three selectors, reset codes 0, 1, 2; no change while the drive operates.
// - Code 0 on while run command on or output voltage present.
// - Code 37 on only while frequency output, off in baseblock, DC braking, stop.
// - Code 1 on below zero-speed level: 0.1, 0.5 or 1.2 Hz per mode.
// - Code 43 is inverse of zero-speed status.
// - Code 6 on once startup initialisation finished without fault.
// - Code 7 on while DC bus undervoltage detected.
// - Code 8 on while output stage is held in baseblock.
// - Code 9 on when keypad is frequency reference source.
// - Code A on when keypad is run command source.
// - Code E on any major fault except two excluded codes; ignores minor faults.
// - Code 10 on whenever a minor fault occurs.
// - Code 11 on while a fault reset command is input.
// - Code 1A on while reverse run active, also in DC braking and baseblock.
// - Code 1B off while baseblock command input asserted, on otherwise.
// - Code 1C off for motor 1, on for motor 2.
// - Code 1D on while motor runs regeneratively.
// - Code 40 closes when brake must be released.
// - Code 41 closes when motor contactors must be closed.
// - Code 38 on while any cooling fan runs.
// - Code 42 compares speed with door-zone level during deceleration; off on release.
// - Codes 46 and 47 switch when both hardware baseblock inputs are enabled.
// - Code 12 follows timer input after on-delay and off-delay.
package mfo_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_SEL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_DZ_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_TMR_ON = 8'h0C;
  localparam logic [7:0] ADDR_TMR_OFF = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // Field positions
  localparam int SEL1_LSB = 0;
  localparam int SEL2_LSB = 8;
  localparam int SEL3_LSB = 16;
  localparam int ST_ZS_BIT = 3;
  localparam int ST_DZ_BIT = 4;
  localparam int ST_TMR_BIT = 5;
  localparam int ST_OPER_BIT = 6;
  localparam int ST_REFUSED_BIT = 8;
  // Reset values
  localparam logic [7:0] SEL1_RST = 8'h00;
  localparam logic [7:0] SEL2_RST = 8'h01;
  localparam logic [7:0] SEL3_RST = 8'h02;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] DZ_LEVEL_RST = 16'h0000;
  localparam logic [15:0] TMR_RST = 16'h0000;
  // Control modes
  localparam logic [1:0] MODE_VF = 2'h0;
  localparam logic [1:0] MODE_OLV = 2'h1;
  localparam logic [1:0] MODE_CLV = 2'h2;
  localparam logic [1:0] MODE_CLV_PM = 2'h3;
  // Zero-speed levels in 0.01 Hz units (0.1, 0.5 and 1.2 Hz)
  localparam logic [15:0] ZS_LVL_CLV = 16'h000A;
  localparam logic [15:0] ZS_LVL_OLV = 16'h0032;
  localparam logic [15:0] ZS_LVL_VF = 16'h0078;
  // Excluded fault codes; values are arbitrary
  localparam logic [7:0] EXCL_FAULT_A = 8'h01;
  localparam logic [7:0] EXCL_FAULT_B = 8'h02;
  // Timer tick: 1 ms at a 10 ns clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Function codes
  localparam logic [7:0] FN_RUN = 8'h00;
  localparam logic [7:0] FN_ZERO_SPD = 8'h01;
  localparam logic [7:0] FN_FREQ_AGREE = 8'h02;
  localparam logic [7:0] FN_READY = 8'h06;
  localparam logic [7:0] FN_UNDERVOLT = 8'h07;
  localparam logic [7:0] FN_BASEBLOCK = 8'h08;
  localparam logic [7:0] FN_FREF_KP = 8'h09;
  localparam logic [7:0] FN_RUN_KP = 8'h0A;
  localparam logic [7:0] FN_FAULT = 8'h0E;
  localparam logic [7:0] FN_MINOR = 8'h10;
  localparam logic [7:0] FN_FRST = 8'h11;
  localparam logic [7:0] FN_TIMER = 8'h12;
  localparam logic [7:0] FN_REVERSE = 8'h1A;
  localparam logic [7:0] FN_BB2 = 8'h1B;
  localparam logic [7:0] FN_MOTOR2 = 8'h1C;
  localparam logic [7:0] FN_REGEN = 8'h1D;
  localparam logic [7:0] FN_RESTART = 8'h1E;
  localparam logic [7:0] FN_TORQUE_LIM = 8'h30;
  localparam logic [7:0] FN_ZSERVO_END = 8'h33;
  localparam logic [7:0] FN_RUN2 = 8'h37;
  localparam logic [7:0] FN_FAN = 8'h38;
  localparam logic [7:0] FN_BRAKE = 8'h40;
  localparam logic [7:0] FN_CONTACTOR = 8'h41;
  localparam logic [7:0] FN_DOOR_ZONE = 8'h42;
  localparam logic [7:0] FN_NOT_ZERO = 8'h43;
  localparam logic [7:0] FN_LL_FWD = 8'h44;
  localparam logic [7:0] FN_LL_REV = 8'h45;
  localparam logic [7:0] FN_BLK_MON1 = 8'h46;
  localparam logic [7:0] FN_BLK_MON2 = 8'h47;
endpackage : mfo_pkg

// file: hdl/mfo_on_off_timer.sv
// On/off delay timer counted in 1 ms ticks
`timescale 1ns/1ps
module mfo_on_off_timer #(
  parameter int unsigned TICK_CYCLES = mfo_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic level_in,
  input wire logic [15:0] on_delay,
  input wire logic [15:0] off_delay,
  output logic level_out
);
  typedef struct packed {
    logic [31:0] presc;
    logic [15:0] cnt;
    logic out;
  } mfo_tmr_t;

  mfo_tmr_t q;
  mfo_tmr_t d;
  logic tick;

  always_comb begin
    d = q;
    tick = (q.presc == 32'(TICK_CYCLES - 1));
    if (tick) begin
      d.presc = 32'h0;
    end else begin
      d.presc = q.presc + 32'h1;
    end
    // Any return to the current state restarts the delay
    if (level_in == q.out) begin
      d.cnt = 16'h0;
    end else if (tick) begin
      if (q.cnt >= (q.out ? off_delay : on_delay)) begin
        d.out = level_in;
        d.cnt = 16'h0;
      end else begin
        d.cnt = q.cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.out;
endmodule : mfo_on_off_timer

// file: hdl/mfo_status_out_sel.sv
// Multifunction output terminal selector with Avalon-MM register access
`timescale 1ns/1ps
module mfo_status_out_sel #(
  parameter int unsigned TICK_CYCLES = mfo_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Drive status, same clock
  input wire logic run_cmd,
  input wire logic volt_out,
  input wire logic freq_out_active,
  input wire logic dc_inj,
  input wire logic baseblock,
  input wire logic [15:0] freq_out,
  input wire logic [15:0] motor_speed,
  input wire logic decel,
  input wire logic updown_cmd,
  input wire logic init_done,
  input wire logic fault_major,
  input wire logic [7:0] fault_code,
  input wire logic minor_fault,
  input wire logic undervolt,
  input wire logic fref_keypad,
  input wire logic run_src_keypad,
  input wire logic fault_reset_in,
  input wire logic reverse_cmd,
  input wire logic blk_cmd_in,
  input wire logic motor2_sel,
  input wire logic regen,
  input wire logic brake_release,
  input wire logic contactor_close,
  input wire logic fan_on,
  input wire logic freq_agree,
  input wire logic restart_en,
  input wire logic torque_limit,
  input wire logic zero_servo_end,
  input wire logic light_load_fwd,
  input wire logic light_load_rev,
  // Pins from outside the clock domain
  input wire logic hw_block_in_a,
  input wire logic hw_block_in_b,
  input wire logic timer_in,
  // Terminals
  output logic term1_out,
  output logic term2_out,
  output logic term3_out
);
  typedef struct packed {
    logic run;
    logic zero_spd;
    logic freq_agree;
    logic ready;
    logic uv;
    logic blk;
    logic fref_kp;
    logic run_kp;
    logic fault;
    logic minor;
    logic frst;
    logic timer;
    logic rev;
    logic bb2;
    logic m2;
    logic regen;
    logic restart;
    logic tlim;
    logic zservo;
    logic run2;
    logic fan;
    logic brake;
    logic cont;
    logic dz;
    logic llf;
    logic llr;
    logic bbmon;
  } mfo_src_t;

  typedef struct packed {
    logic [7:0] out_term1_func_sel;
    logic [7:0] out_term2_func_sel;
    logic [7:0] out_term3_func_sel;
    logic [1:0] mode;
    logic [15:0] door_zone_speed_level;
    logic [15:0] timer_on_delay;
    logic [15:0] timer_off_delay;
    logic sel_refused;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] bba_sync;
    logic [1:0] bbb_sync;
    logic [1:0] tmr_sync;
    logic dz;
    logic [2:0] term;
  } mfo_state_t;

  mfo_state_t q;
  mfo_state_t d;
  mfo_src_t src;
  logic timer_out;
  logic operating;
  logic [15:0] zs_level;
  logic zero_spd;
  logic [15:0] dz_speed;
  logic [31:0] status_word;
  logic [31:0] sel_word;
  logic req;

  // Byte-lane merge of a write into a stored register
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Terminal level for one function code
  function automatic logic select_out(input logic [7:0] code, input mfo_src_t s);
    logic r;
    r = 1'b0;
    case (code)
      mfo_pkg::FN_RUN: r = s.run;
      mfo_pkg::FN_ZERO_SPD: r = s.zero_spd;
      mfo_pkg::FN_NOT_ZERO: r = ~s.zero_spd;
      mfo_pkg::FN_RUN2: r = s.run2;
      mfo_pkg::FN_READY: r = s.ready;
      mfo_pkg::FN_UNDERVOLT: r = s.uv;
      mfo_pkg::FN_BASEBLOCK: r = s.blk;
      mfo_pkg::FN_FREF_KP: r = s.fref_kp;
      mfo_pkg::FN_RUN_KP: r = s.run_kp;
      mfo_pkg::FN_FAULT: r = s.fault;
      mfo_pkg::FN_MINOR: r = s.minor;
      mfo_pkg::FN_FRST: r = s.frst;
      mfo_pkg::FN_TIMER: r = s.timer;
      mfo_pkg::FN_REVERSE: r = s.rev;
      mfo_pkg::FN_BB2: r = s.bb2;
      mfo_pkg::FN_MOTOR2: r = s.m2;
      mfo_pkg::FN_REGEN: r = s.regen;
      mfo_pkg::FN_BRAKE: r = s.brake;
      mfo_pkg::FN_CONTACTOR: r = s.cont;
      mfo_pkg::FN_FAN: r = s.fan;
      mfo_pkg::FN_DOOR_ZONE: r = s.dz;
      mfo_pkg::FN_BLK_MON1: r = s.bbmon;
      mfo_pkg::FN_BLK_MON2: r = ~s.bbmon;
      mfo_pkg::FN_FREQ_AGREE: r = s.freq_agree;
      mfo_pkg::FN_RESTART: r = s.restart;
      mfo_pkg::FN_TORQUE_LIM: r = s.tlim;
      mfo_pkg::FN_ZSERVO_END: r = s.zservo;
      mfo_pkg::FN_LL_FWD: r = s.llf;
      mfo_pkg::FN_LL_REV: r = s.llr;
      // Unknown codes hold the terminal off
      default: r = 1'b0;
    endcase
    return r;
  endfunction : select_out

  // Timer function fed from the synchronised timer pin
  mfo_on_off_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .level_in(q.tmr_sync[1]),
    .on_delay(q.timer_on_delay),
    .off_delay(q.timer_off_delay),
    .level_out(timer_out)
  );

  // The drive counts as operating while commanded or while voltage is out
  assign operating = run_cmd | volt_out;

  // Zero-speed level follows the control mode
  always_comb begin
    case (q.mode)
      mfo_pkg::MODE_VF: zs_level = mfo_pkg::ZS_LVL_VF;
      mfo_pkg::MODE_OLV: zs_level = mfo_pkg::ZS_LVL_OLV;
      default: zs_level = mfo_pkg::ZS_LVL_CLV;
    endcase
  end

  assign zero_spd = (freq_out < zs_level);

  // Closed loop compares motor speed, the others output frequency
  assign dz_speed = (q.mode == mfo_pkg::MODE_CLV || q.mode == mfo_pkg::MODE_CLV_PM) ?
                    motor_speed : freq_out;

  always_comb begin
    src = '0;
    src.run = run_cmd | volt_out;
    src.run2 = freq_out_active & ~baseblock & ~dc_inj;
    src.zero_spd = zero_spd;
    src.ready = init_done & ~fault_major;
    src.uv = undervolt;
    src.blk = baseblock;
    src.fref_kp = fref_keypad;
    src.run_kp = run_src_keypad;
    src.fault = fault_major & (fault_code != mfo_pkg::EXCL_FAULT_A) &
                (fault_code != mfo_pkg::EXCL_FAULT_B);
    src.minor = minor_fault;
    src.frst = fault_reset_in;
    src.timer = timer_out;
    // Direction comes from the command, so DC braking and baseblock keep it
    src.rev = reverse_cmd;
    src.bb2 = ~blk_cmd_in;
    src.m2 = motor2_sel;
    src.regen = regen;
    src.brake = brake_release;
    src.cont = contactor_close;
    src.fan = fan_on;
    src.dz = q.dz;
    src.bbmon = q.bba_sync[1] & q.bbb_sync[1];
    src.freq_agree = freq_agree;
    src.restart = restart_en;
    src.tlim = torque_limit;
    src.zservo = zero_servo_end;
    src.llf = light_load_fwd;
    src.llr = light_load_rev;
  end

  assign sel_word = {8'h00, q.out_term3_func_sel, q.out_term2_func_sel,
                     q.out_term1_func_sel};

  always_comb begin
    status_word = 32'h0;
    status_word[2:0] = q.term;
    status_word[mfo_pkg::ST_ZS_BIT] = zero_spd;
    status_word[mfo_pkg::ST_DZ_BIT] = q.dz;
    status_word[mfo_pkg::ST_TMR_BIT] = timer_out;
    status_word[mfo_pkg::ST_OPER_BIT] = operating;
    status_word[mfo_pkg::ST_REFUSED_BIT] = q.sel_refused;
  end

  // One wait cycle per access keeps read data registered
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~q.ack;

  always_comb begin
    logic [31:0] merged;
    logic refuse_set;
    logic refuse_clr;
    merged = 32'h0;
    refuse_set = 1'b0;
    refuse_clr = 1'b0;
    d = q;
    d.ack = req & ~q.ack;
    // Pins pass two flops before use
    d.bba_sync = {q.bba_sync[0], hw_block_in_a};
    d.bbb_sync = {q.bbb_sync[0], hw_block_in_b};
    d.tmr_sync = {q.tmr_sync[0], timer_in};
    if (avs_read && !q.ack) begin
      case ({avs_address[7:2], 2'b00})
        mfo_pkg::ADDR_SEL: d.rdata = sel_word;
        mfo_pkg::ADDR_CFG: d.rdata = {30'h0, q.mode};
        mfo_pkg::ADDR_DZ_LEVEL: d.rdata = {16'h0, q.door_zone_speed_level};
        mfo_pkg::ADDR_TMR_ON: d.rdata = {16'h0, q.timer_on_delay};
        mfo_pkg::ADDR_TMR_OFF: d.rdata = {16'h0, q.timer_off_delay};
        mfo_pkg::ADDR_STATUS: d.rdata = status_word;
        default: d.rdata = 32'h0;
      endcase
    end
    // Writes take effect at the edge after the wait, where waitrequest is sampled low
    if (avs_write && q.ack) begin
      case ({avs_address[7:2], 2'b00})
        mfo_pkg::ADDR_SEL: begin
          if (operating) begin
            refuse_set = 1'b1;
          end else begin
            merged = be_merge(sel_word, avs_writedata, avs_byteenable);
            d.out_term1_func_sel = merged[mfo_pkg::SEL1_LSB +: 8];
            d.out_term2_func_sel = merged[mfo_pkg::SEL2_LSB +: 8];
            d.out_term3_func_sel = merged[mfo_pkg::SEL3_LSB +: 8];
          end
        end
        mfo_pkg::ADDR_CFG: begin
          merged = be_merge({30'h0, q.mode}, avs_writedata, avs_byteenable);
          d.mode = merged[1:0];
        end
        mfo_pkg::ADDR_DZ_LEVEL: begin
          merged = be_merge({16'h0, q.door_zone_speed_level}, avs_writedata,
                            avs_byteenable);
          d.door_zone_speed_level = merged[15:0];
        end
        mfo_pkg::ADDR_TMR_ON: begin
          merged = be_merge({16'h0, q.timer_on_delay}, avs_writedata, avs_byteenable);
          d.timer_on_delay = merged[15:0];
        end
        mfo_pkg::ADDR_TMR_OFF: begin
          merged = be_merge({16'h0, q.timer_off_delay}, avs_writedata, avs_byteenable);
          d.timer_off_delay = merged[15:0];
        end
        mfo_pkg::ADDR_STATUS: begin
          refuse_clr = avs_byteenable[1] & avs_writedata[mfo_pkg::ST_REFUSED_BIT];
        end
        default: begin
          merged = 32'h0;
        end
      endcase
    end
    // A refusal in the clearing cycle survives the clear
    if (refuse_set) begin
      d.sel_refused = 1'b1;
    end else if (refuse_clr) begin
      d.sel_refused = 1'b0;
    end
    // Door zone holds between deceleration phases, drops on command release
    if (!updown_cmd) begin
      d.dz = 1'b0;
    end else if (decel) begin
      d.dz = (dz_speed > q.door_zone_speed_level);
    end
    d.term[0] = select_out(q.out_term1_func_sel, src);
    d.term[1] = select_out(q.out_term2_func_sel, src);
    d.term[2] = select_out(q.out_term3_func_sel, src);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.out_term1_func_sel <= mfo_pkg::SEL1_RST;
      q.out_term2_func_sel <= mfo_pkg::SEL2_RST;
      q.out_term3_func_sel <= mfo_pkg::SEL3_RST;
      q.mode <= mfo_pkg::MODE_RST;
      q.door_zone_speed_level <= mfo_pkg::DZ_LEVEL_RST;
      q.timer_on_delay <= mfo_pkg::TMR_RST;
      q.timer_off_delay <= mfo_pkg::TMR_RST;
      q.term <= 3'h0;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata = q.rdata;
  assign term1_out = q.term[0];
  assign term2_out = q.term[1];
  assign term3_out = q.term[2];
endmodule : mfo_status_out_sel

// file: verif/mfo_status_out_sel_sva.sv
// Port assertions for the output terminal selector
`timescale 1ns/1ps
module mfo_status_out_sel_sva #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic run_cmd,
  input wire logic volt_out,
  input wire logic freq_out_active,
  input wire logic dc_inj,
  input wire logic baseblock,
  input wire logic fault_major,
  input wire logic [7:0] fault_code,
  input wire logic blk_cmd_in,
  input wire logic hw_block_in_a,
  input wire logic hw_block_in_b,
  input wire logic term1_out,
  input wire logic term2_out,
  input wire logic term3_out
);
  logic [15:0] sel_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shadow of selectors 1 and 2; refused while operating
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_q <= 16'h0100;
    end else if (avs_write && !avs_waitrequest && avs_address[7:2] == 6'h00
                 && !(run_cmd || volt_out)) begin
      sel_q <= {avs_byteenable[1] ? avs_writedata[15:8] : sel_q[15:8],
                avs_byteenable[0] ? avs_writedata[7:0] : sel_q[7:0]};
    end
  end
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address >= 8'h18 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_run_term: assert property (sel_q[7:0] == 8'h00 |=> term1_out == $past(run_cmd || volt_out))
    else $error("run output wrong");
  a_run2_term: assert property (sel_q[7:0] == 8'h37
    |=> term1_out == $past(freq_out_active && !baseblock && !dc_inj))
    else $error("run 2 output wrong");
  a_fault_term: assert property (sel_q[7:0] == 8'h0E |=> term1_out == $past(fault_major
    && fault_code != mfo_pkg::EXCL_FAULT_A && fault_code != mfo_pkg::EXCL_FAULT_B))
    else $error("fault output wrong");
  a_bb2_term: assert property (sel_q[7:0] == 8'h1B |=> term1_out == !$past(blk_cmd_in))
    else $error("block command output wrong");
  a_mon1_term: assert property ((sel_q[7:0] == 8'h46) [*4]
    |-> term1_out == $past(hw_block_in_a && hw_block_in_b, 3))
    else $error("block monitor 1 wrong");
  a_mon2_term: assert property ((sel_q[15:8] == 8'h47) [*4]
    |-> term2_out == !$past(hw_block_in_a && hw_block_in_b, 3))
    else $error("block monitor 2 wrong");
  a_term_rst: assert property (disable iff (1'b0) rst |-> !term1_out && !term2_out && !term3_out)
    else $error("terminal on during reset");
endmodule : mfo_status_out_sel_sva

bind mfo_status_out_sel mfo_status_out_sel_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .run_cmd(run_cmd),
  .volt_out(volt_out), .freq_out_active(freq_out_active), .dc_inj(dc_inj),
  .baseblock(baseblock), .fault_major(fault_major), .fault_code(fault_code),
  .blk_cmd_in(blk_cmd_in), .hw_block_in_a(hw_block_in_a), .hw_block_in_b(hw_block_in_b),
  .term1_out(term1_out), .term2_out(term2_out), .term3_out(term3_out));

// file: verif/mfo_lift_partner.sv
// Safety circuit model driving the two hardware block pins
`timescale 1ns/1ps
module mfo_lift_partner (
  input wire logic core_clk,
  input wire logic want_block,
  input wire logic slow,
  output logic hw_block_in_a,
  output logic hw_block_in_b
);
  int lag;
  initial begin
    hw_block_in_a = 1'b0;
    hw_block_in_b = 1'b0;
  end
  // Channels never switch together: the second lags, so both-on is seen late
  always @(want_block) begin
    #3 hw_block_in_a = want_block;
    lag = slow ? 5 : 1;
    repeat (lag) @(posedge core_clk);
    #3 hw_block_in_b = want_block;
  end
endmodule : mfo_lift_partner

// file: verif/mfo_status_out_sel_tb.sv
// Self-checking bench for the output terminal selector
`timescale 1ns/1ps
module mfo_status_out_sel_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [26:0] sb = '0;
  logic [15:0] freq = 16'h0;
  logic [15:0] mspd = 16'h0;
  logic [7:0] fcode = 8'h0;
  logic timer_in = 1'b0;
  logic want = 1'b0;
  logic slow = 1'b0;
  logic blk_a, blk_b, t1, t2, t3;
  logic [1:0] mode_v = 2'h0;
  logic [31:0] lfsr = 32'h56F1;
  logic [31:0] rd;
  int failures = 0;
  int checks_done = 0;
  int n;
  logic [7:0] codes [26] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0E,
    8'h10, 8'h11, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h30, 8'h33, 8'h37, 8'h38, 8'h40,
    8'h41, 8'h43, 8'h44, 8'h45, 8'h05};
  always #5 core_clk = ~core_clk;
  mfo_status_out_sel #(.TICK_CYCLES(4)) uut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .run_cmd(sb[0]), .volt_out(sb[1]), .freq_out_active(sb[2]), .dc_inj(sb[3]),
    .baseblock(sb[4]), .freq_out(freq), .motor_speed(mspd), .decel(sb[5]),
    .updown_cmd(sb[6]), .init_done(sb[7]), .fault_major(sb[8]), .fault_code(fcode),
    .minor_fault(sb[9]), .undervolt(sb[10]), .fref_keypad(sb[11]), .run_src_keypad(sb[12]),
    .fault_reset_in(sb[13]), .reverse_cmd(sb[14]), .blk_cmd_in(sb[15]), .motor2_sel(sb[16]),
    .regen(sb[17]), .brake_release(sb[18]), .contactor_close(sb[19]), .fan_on(sb[20]),
    .freq_agree(sb[21]), .restart_en(sb[22]), .torque_limit(sb[23]),
    .zero_servo_end(sb[24]), .light_load_fwd(sb[25]), .light_load_rev(sb[26]),
    .hw_block_in_a(blk_a), .hw_block_in_b(blk_b), .timer_in(timer_in),
    .term1_out(t1), .term2_out(t2), .term3_out(t3));
  mfo_lift_partner u_partner (.core_clk(core_clk), .want_block(want), .slow(slow),
    .hw_block_in_a(blk_a), .hw_block_in_b(blk_b));

  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt
  function automatic logic [15:0] zlv();
    return mode_v == 2'h0 ? 16'h0078 : (mode_v == 2'h1 ? 16'h0032 : 16'h000A);
  endfunction : zlv
  function automatic logic expv(input logic [7:0] c);
    case (c)
      8'h00: return sb[0] | sb[1];
      8'h01: return freq < zlv();
      8'h02: return sb[21];
      8'h06: return sb[7] & ~sb[8];
      8'h07: return sb[10];
      8'h08: return sb[4];
      8'h09: return sb[11];
      8'h0A: return sb[12];
      8'h0E: return sb[8] && fcode != mfo_pkg::EXCL_FAULT_A && fcode != mfo_pkg::EXCL_FAULT_B;
      8'h10: return sb[9];
      8'h11: return sb[13];
      8'h1A: return sb[14];
      8'h1B: return ~sb[15];
      8'h1C: return sb[16];
      8'h1D: return sb[17];
      8'h1E: return sb[22];
      8'h30: return sb[23];
      8'h33: return sb[24];
      8'h37: return sb[2] & ~sb[4] & ~sb[3];
      8'h38: return sb[20];
      8'h40: return sb[18];
      8'h41: return sb[19];
      8'h43: return !(freq < zlv());
      8'h44: return sb[25];
      8'h45: return sb[26];
      default: return 1'b0;
    endcase
  endfunction : expv

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk iff avs_waitrequest === 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic dzs(input logic dec, input logic ud, input logic [15:0] f, input logic e);
    sb[5] <= dec;
    sb[6] <= ud;
    freq <= f;
    repeat (3) @(posedge core_clk);
    #1;
    chk("door_zone", {31'h0, e}, {31'h0, t1});
  endtask : dzs

  initial begin
    #(20000 * 10);
    failures++;
    complete_run();
  end
  initial begin
    // A real edge on reset clears the flops before the first clock edge
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("term_rst", 32'h0, {29'h0, t3, t2, t1});
    rst <= 1'b0;
    bus(1'b0, 8'h00, 32'h0, 4'hF, rd);
    chk("sel_rst", 32'h00020100, rd);
    bus(1'b0, 8'h20, 32'h0, 4'hF, rd);
    chk("unmapped", 32'h0, rd);
    sb[0] <= 1'b1;
    bus(1'b1, 8'h00, 32'h00080808, 4'hF, rd);
    bus(1'b0, 8'h00, 32'h0, 4'hF, rd);
    chk("sel_refused", 32'h00020100, rd);
    bus(1'b0, 8'h14, 32'h0, 4'hF, rd);
    chk("refused_flag", 32'h1, {31'h0, rd[8]});
    sb <= '0;
    bus(1'b1, 8'h14, 32'h00000100, 4'h2, rd);
    bus(1'b0, 8'h14, 32'h0, 4'hF, rd);
    chk("flag_clear", 32'h0, {31'h0, rd[8]});
    for (int m = 0; m < 4; m++) begin
      mode_v = m[1:0];
      bus(1'b1, 8'h04, {30'h0, mode_v}, 4'hF, rd);
      for (int i = 0; i < 26; i++) begin
        sb <= '0;
        bus(1'b1, 8'h00, {8'h00, codes[(i + 2) % 26], codes[(i + 1) % 26], codes[i]}, 4'hF, rd);
        for (int j = 0; j < 6; j++) begin
          lfsr = nxt(lfsr);
          sb <= lfsr[26:0];
          freq <= (j == 0) ? zlv() : {8'h00, lfsr[31:24]};
          fcode <= {6'h00, lfsr[28:27]};
          mspd <= lfsr[15:0];
          @(posedge core_clk);
          #1;
          chk("term1", {31'h0, expv(codes[i])}, {31'h0, t1});
          chk("term2", {31'h0, expv(codes[(i + 1) % 26])}, {31'h0, t2});
          chk("term3", {31'h0, expv(codes[(i + 2) % 26])}, {31'h0, t3});
        end
      end
    end
    sb <= '0;
    mspd <= 16'h0096;
    bus(1'b1, 8'h04, 32'h0, 4'hF, rd);
    bus(1'b1, 8'h08, 32'h00000064, 4'hF, rd);
    bus(1'b1, 8'h00, 32'h00000042, 4'hF, rd);
    dzs(1'b1, 1'b1, 16'h0096, 1'b1);
    dzs(1'b1, 1'b1, 16'h0032, 1'b0);
    dzs(1'b0, 1'b1, 16'h0096, 1'b0);
    dzs(1'b1, 1'b1, 16'h0096, 1'b1);
    dzs(1'b1, 1'b0, 16'h0096, 1'b0);
    bus(1'b1, 8'h04, 32'h2, 4'hF, rd);
    dzs(1'b1, 1'b1, 16'h0010, 1'b1);
    sb <= '0;
    bus(1'b1, 8'h0C, 32'h2, 4'hF, rd);
    bus(1'b1, 8'h10, 32'h1, 4'hF, rd);
    bus(1'b1, 8'h00, 32'h00124746, 4'hF, rd);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      want <= 1'b1;
      repeat (12) @(posedge core_clk);
      #1;
      chk("block_mon", 32'h1, {30'h0, t2, t1});
      want <= 1'b0;
      repeat (12) @(posedge core_clk);
      #1;
      chk("block_mon", 32'h2, {30'h0, t2, t1});
    end
    timer_in <= 1'b1;
    n = 0;
    while (t3 !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("timer_on", 32'h1, {31'h0, n >= 8 && n <= 20});
    timer_in <= 1'b0;
    n = 0;
    while (t3 !== 1'b0 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("timer_off", 32'h1, {31'h0, n >= 4 && n <= 16});
    complete_run();
  end
endmodule : mfo_status_out_sel_tb
